// ### core/eqf_defs.vh
/*
 Constants for the equaliser filter coefficient block, taps six to eight.
 Assumes a parallel register port addressed by the documented offsets.
*/
`ifndef EQF_DEFS_VH
`define EQF_DEFS_VH
`define EQF_ADDR_W 12
`define EQF_OFS_TAP6 12'h423
`define EQF_OFS_TAP7 12'h425
`define EQF_OFS_TAP8 12'h427
`define EQF_REG_W 16
`define EQF_COEF_MSB 11
`define EQF_COEF_W 12
`define EQF_CENTER_W 18
`define EQF_REG_RESET 16'h0000
`define EQF_SAMPLE_W 12
`define EQF_NUM_TAPS 9
`define EQF_ACC_W 36
`endif

// ### core/eqf_mac.v
/*
 Nine-tap multiply-accumulate datapath of the equaliser filter.
 Assumes coefficients are stable or change only between samples.
*/
`include "eqf_defs.vh"
module eqf_mac (
	input wire clk,
	input wire reset,
	input wire sample_valid,
	input wire signed [`EQF_SAMPLE_W-1:0] sample_in,
	input wire [9*`EQF_CENTER_W-1:0] coef_flat,
	output reg signed [`EQF_ACC_W-1:0] filter_out_ff,
	output reg filter_valid_ff
);
	reg signed [`EQF_SAMPLE_W-1:0] delay_ff [0:8];
	reg signed [`EQF_ACC_W-1:0] acc;
	integer i;
	integer j;

	// ----------------------------------------
	// Delay line and sum of tap products
	// ----------------------------------------
	always @* begin
		acc = {`EQF_ACC_W{1'h0}};
		for (i = 0; i < `EQF_NUM_TAPS; i = i + 1) begin
			acc = acc + $signed(coef_flat[i*`EQF_CENTER_W +: `EQF_CENTER_W]) * delay_ff[i];
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			for (j = 0; j < `EQF_NUM_TAPS; j = j + 1) begin
				delay_ff[j] <= {`EQF_SAMPLE_W{1'h0}};
			end
			filter_out_ff <= {`EQF_ACC_W{1'h0}};
			filter_valid_ff <= 1'h0;
		end else begin
			filter_valid_ff <= sample_valid;
			if (sample_valid) begin
				delay_ff[0] <= sample_in;
				for (j = 1; j < `EQF_NUM_TAPS; j = j + 1) begin
					delay_ff[j] <= delay_ff[j-1];
				end
				filter_out_ff <= acc;
			end
		end
	end
endmodule

// ### core/eqf_coef_taps.v
/*
 Coefficient registers for equaliser taps six to eight plus the filter datapath.
 Assumes a synchronous register port; other taps arrive as ports from elsewhere.
*/
`include "eqf_defs.vh"
// Summary of operation
// - Coefficient is signed twelve low bits
// - Offset 0x423 feeds tap six, channel A
// - Offset 0x425 feeds tap seven, channel A
// - Offset 0x427 feeds tap eight, channel A
// - Single mode: same taps feed shared filter
// - Reset clears all coefficient registers
// - Upper four bits stored, ignored by filter
// - Nine taps, centre tap eighteen bits
module eqf_coef_taps (
	input wire clk,
	input wire reset,
	input wire reg_wr,
	input wire reg_rd,
	input wire [`EQF_ADDR_W-1:0] reg_addr,
	input wire [`EQF_REG_W-1:0] reg_wdata,
	output reg [`EQF_REG_W-1:0] reg_rdata_ff,
	output reg reg_hit_ff,
	input wire single_channel_mode,
	input wire [4*`EQF_COEF_W-1:0] low_taps_coef,
	input wire [`EQF_CENTER_W-1:0] center_tap_coef,
	input wire [`EQF_COEF_W-1:0] tap_nine_coef,
	input wire sample_valid,
	input wire [`EQF_SAMPLE_W-1:0] sample_in,
	output wire [`EQF_ACC_W-1:0] filter_out,
	output wire filter_valid,
	output wire filter_serves_channel_a
);
	// ----------------------------------------
	// Storage and next values
	// ----------------------------------------
	reg [`EQF_REG_W-1:0] equaliser_tap_six_coef_ff;
	reg [`EQF_REG_W-1:0] equaliser_tap_seven_coef_ff;
	reg [`EQF_REG_W-1:0] equaliser_tap_eight_coef_ff;
	reg [`EQF_REG_W-1:0] nxt_equaliser_tap_six_coef;
	reg [`EQF_REG_W-1:0] nxt_equaliser_tap_seven_coef;
	reg [`EQF_REG_W-1:0] nxt_equaliser_tap_eight_coef;
	reg [`EQF_REG_W-1:0] nxt_reg_rdata;
	reg nxt_reg_hit;
	wire [2:0] wr_sel;
	wire [2:0] rd_sel;

	// Coefficient slices in tap order
	wire [`EQF_COEF_W-1:0] tap_one_field;
	wire [`EQF_COEF_W-1:0] tap_two_field;
	wire [`EQF_COEF_W-1:0] tap_three_field;
	wire [`EQF_COEF_W-1:0] tap_four_field;
	wire [`EQF_CENTER_W-1:0] tap_one_wide;
	wire [`EQF_CENTER_W-1:0] tap_two_wide;
	wire [`EQF_CENTER_W-1:0] tap_three_wide;
	wire [`EQF_CENTER_W-1:0] tap_four_wide;
	wire [`EQF_CENTER_W-1:0] tap_five_wide;
	wire [`EQF_CENTER_W-1:0] tap_six_wide;
	wire [`EQF_CENTER_W-1:0] tap_seven_wide;
	wire [`EQF_CENTER_W-1:0] tap_eight_wide;
	wire [`EQF_CENTER_W-1:0] tap_nine_wide;
	wire [9*`EQF_CENTER_W-1:0] coef_flat;
	wire signed [`EQF_ACC_W-1:0] mac_out;

	// ----------------------------------------
	// Shared helpers
	// ----------------------------------------
	// Sign-extends a 12-bit field to the 18-bit tap width; bits 15:12 dropped here
	function [`EQF_CENTER_W-1:0] widen;
		input [`EQF_REG_W-1:0] r;
		begin
			widen = {{(`EQF_CENTER_W-`EQF_COEF_W){r[`EQF_COEF_MSB]}}, r[`EQF_COEF_MSB:0]};
		end
	endfunction

	// One decoder for both strobes, so writes and reads always agree on the map
	function [2:0] tap_select;
		input [`EQF_ADDR_W-1:0] a;
		begin
			case (a)
				`EQF_OFS_TAP6: tap_select = 3'h1;
				`EQF_OFS_TAP7: tap_select = 3'h2;
				`EQF_OFS_TAP8: tap_select = 3'h4;
				default: tap_select = 3'h0;
			endcase
		end
	endfunction

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	// Both strobes in one cycle: the read still sees the value held before the write
	assign wr_sel = reg_wr ? tap_select(reg_addr) : 3'h0;
	assign rd_sel = reg_rd ? tap_select(reg_addr) : 3'h0;

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	// Reserved bits are kept as written so a read returns them
	always @* begin
		nxt_equaliser_tap_six_coef = equaliser_tap_six_coef_ff;
		if (wr_sel[0]) begin
			nxt_equaliser_tap_six_coef = reg_wdata;
		end
	end

	always @* begin
		nxt_equaliser_tap_seven_coef = equaliser_tap_seven_coef_ff;
		if (wr_sel[1]) begin
			nxt_equaliser_tap_seven_coef = reg_wdata;
		end
	end

	always @* begin
		nxt_equaliser_tap_eight_coef = equaliser_tap_eight_coef_ff;
		if (wr_sel[2]) begin
			nxt_equaliser_tap_eight_coef = reg_wdata;
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			equaliser_tap_six_coef_ff <= `EQF_REG_RESET;
		end else begin
			equaliser_tap_six_coef_ff <= nxt_equaliser_tap_six_coef;
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			equaliser_tap_seven_coef_ff <= `EQF_REG_RESET;
		end else begin
			equaliser_tap_seven_coef_ff <= nxt_equaliser_tap_seven_coef;
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			equaliser_tap_eight_coef_ff <= `EQF_REG_RESET;
		end else begin
			equaliser_tap_eight_coef_ff <= nxt_equaliser_tap_eight_coef;
		end
	end

	// ----------------------------------------
	// Register reads
	// ----------------------------------------
	// Unmapped offsets answer zero with no hit
	always @* begin
		nxt_reg_rdata = reg_rdata_ff;
		nxt_reg_hit = 1'h0;
		if (reg_rd) begin
			case (rd_sel)
				3'h1: nxt_reg_rdata = equaliser_tap_six_coef_ff;
				3'h2: nxt_reg_rdata = equaliser_tap_seven_coef_ff;
				3'h4: nxt_reg_rdata = equaliser_tap_eight_coef_ff;
				default: nxt_reg_rdata = `EQF_REG_RESET;
			endcase
			nxt_reg_hit = |rd_sel;
		end
	end

	// Read data holds until the next read, so software may fetch it late
	always @(posedge clk) begin
		if (reset) begin
			reg_rdata_ff <= `EQF_REG_RESET;
			reg_hit_ff <= 1'h0;
		end else begin
			reg_rdata_ff <= nxt_reg_rdata;
			reg_hit_ff <= nxt_reg_hit;
		end
	end

	// ----------------------------------------
	// Coefficient vector for the nine taps
	// ----------------------------------------
	// Same registers serve channel A or the single filter; only the label changes
	assign filter_serves_channel_a = ~single_channel_mode;

	// Outer taps arrive as bare fields from their own registers
	assign tap_one_field = low_taps_coef[0*`EQF_COEF_W +: `EQF_COEF_W];
	assign tap_two_field = low_taps_coef[1*`EQF_COEF_W +: `EQF_COEF_W];
	assign tap_three_field = low_taps_coef[2*`EQF_COEF_W +: `EQF_COEF_W];
	assign tap_four_field = low_taps_coef[3*`EQF_COEF_W +: `EQF_COEF_W];

	assign tap_one_wide = widen({4'h0, tap_one_field});
	assign tap_two_wide = widen({4'h0, tap_two_field});
	assign tap_three_wide = widen({4'h0, tap_three_field});
	assign tap_four_wide = widen({4'h0, tap_four_field});
	assign tap_five_wide = center_tap_coef;
	assign tap_six_wide = widen(equaliser_tap_six_coef_ff);
	assign tap_seven_wide = widen(equaliser_tap_seven_coef_ff);
	assign tap_eight_wide = widen(equaliser_tap_eight_coef_ff);
	assign tap_nine_wide = widen({4'h0, tap_nine_coef});

	// Tap one sits in the lowest slice to match the delay line order
	assign coef_flat = {
		tap_nine_wide,
		tap_eight_wide,
		tap_seven_wide,
		tap_six_wide,
		tap_five_wide,
		tap_four_wide,
		tap_three_wide,
		tap_two_wide,
		tap_one_wide
	};

	// ----------------------------------------
	// Datapath
	// ----------------------------------------
	// Arithmetic kept apart so the register map can change on its own
	eqf_mac u_mac (
		.clk(clk),
		.reset(reset),
		.sample_valid(sample_valid),
		.sample_in(sample_in),
		.coef_flat(coef_flat),
		.filter_out_ff(mac_out),
		.filter_valid_ff(filter_valid)
	);
	assign filter_out = mac_out;
endmodule

// ### bench/eqf_coef_monitor.sv
/* Port checker for eqf_coef_taps.
 Bound to the design; one clock, sync reset. */
module eqf_coef_monitor(
	input wire clk,
	input wire reset,
	input wire reg_wr,
	input wire reg_rd,
	input wire [11:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire [15:0] reg_rdata_ff,
	input wire reg_hit_ff,
	input wire single_channel_mode,
	input wire sample_valid,
	input wire [35:0] filter_out,
	input wire filter_valid,
	input wire filter_serves_channel_a
);
// ---
// Properties
// ---
default clocking @(posedge clk); endclocking
default disable iff (reset);
wire map = reg_addr == 12'h423 || reg_addr == 12'h425 || reg_addr == 12'h427;
property p_hit; reg_rd && map |=> reg_hit_ff; endproperty
a_hit: assert property (p_hit) else $error("no hit");
property p_miss; reg_rd && !map |=> !reg_hit_ff && reg_rdata_ff == 16'h0; endproperty
a_miss: assert property (p_miss) else $error("bad miss");
property p_back; reg_wr && map ##1 reg_rd && !reg_wr && reg_addr == $past(reg_addr)
	|=> reg_rdata_ff == $past(reg_wdata, 2); endproperty
a_back: assert property (p_back) else $error("readback");
property p_mode; filter_serves_channel_a == !single_channel_mode; endproperty
a_mode: assert property (p_mode) else $error("mode");
property p_fv; sample_valid |=> filter_valid; endproperty
a_fv: assert property (p_fv) else $error("no valid");
property p_nfv; !sample_valid |=> !filter_valid; endproperty
a_nfv: assert property (p_nfv) else $error("extra valid");
property p_idle; !sample_valid |=> $stable(filter_out); endproperty
a_idle: assert property (p_idle) else $error("out moved");
// Own disable, so reset itself is observed
property p_rst; disable iff (1'b0) reset |=> !reg_hit_ff && reg_rdata_ff == 16'h0 && filter_out == 36'h0;
endproperty
a_rst: assert property (p_rst) else $error("reset");
c_back: cover property (reg_wr && map ##1 reg_rd);
c_run: cover property (sample_valid ##1 sample_valid);
c_single: cover property (single_channel_mode && sample_valid);
endmodule
bind eqf_coef_taps eqf_coef_monitor u_mon(.clk(clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .reg_hit_ff(reg_hit_ff),
	.single_channel_mode(single_channel_mode), .sample_valid(sample_valid), .filter_out(filter_out),
	.filter_valid(filter_valid), .filter_serves_channel_a(filter_serves_channel_a));

// ### bench/eqf_coef_taps_tb.sv
/* Bench for eqf_coef_taps.
 Drives register port and sample path; other taps tied to constants. */
module eqf_coef_taps_tb;
timeunit 1ns;
timeprecision 1ns;
logic clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, sv = 0, mode = 0, hit, fv, cha;
logic [11:0] ad = 0, si = 0;
logic [15:0] wd = 0, rdata;
logic [35:0] fo;
logic [11:0] ofs[3] = '{12'h423, 12'h425, 12'h427};
// Reserved bits stay zero in every write
logic [15:0] dat[3] = '{16'h0fff, 16'h0002, 16'h0800};
// Impulse response, tap one first: centre 0x20001, taps six to nine as loaded
logic [35:0] imp[9] = '{36'h0, 36'h0, 36'h0, 36'h0, 36'hffffe0001, 36'hfffffffff, 36'h2, 36'hffffff800,
	36'hffffff801};
int fails = 0, n_compared = 0;
always #50 clk = ~clk;
eqf_coef_taps uut(.clk(clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(ad), .reg_wdata(wd),
	.reg_rdata_ff(rdata), .reg_hit_ff(hit), .single_channel_mode(mode), .low_taps_coef(48'h0),
	.center_tap_coef(18'h20001), .tap_nine_coef(12'h801), .sample_valid(sv), .sample_in(si),
	.filter_out(fo), .filter_valid(fv), .filter_serves_channel_a(cha));
// ---
// Tasks
// ---
task chk(input [36:0] g, e);
	n_compared++;
	if (g !== e) begin
		fails++;
		$display("BAD %0t %h %h", $time, g, e);
	end
endtask
task complete_run;
	$display("compared %0d bad %0d", n_compared, fails);
	if (fails == 0 && n_compared > 0)
		$display("bench passed");
	else
		$display("bench failed");
	$finish;
endtask
// Strobes stay up between back-to-back calls; the caller drops them when done
task wr(input [11:0] a, input [15:0] d);
	reg_wr = 1;
	reg_rd = 0;
	ad = a;
	wd = d;
	@(negedge clk);
endtask
task rd(input [11:0] a, input [15:0] e, input h);
	reg_rd = 1;
	reg_wr = 0;
	ad = a;
	@(negedge clk);
	chk(rdata, e);
	chk(hit, h);
endtask
initial begin
	repeat (16) @(negedge clk);
	reset = 0;
	foreach (ofs[i]) rd(ofs[i], 16'h0, 1);
	foreach (ofs[i]) begin
		wr(ofs[i], dat[i]);
		rd(ofs[i], dat[i], 1);
	end
	wr(12'h426, 16'h0bad);
	rd(12'h425, 16'h0002, 1);
	rd(12'h424, 16'h0, 0);
	reg_rd = 0;
	$display("regs done");
	chk(cha, 1);
	mode = 1;
	sv = 1;
	si = 12'h001;
	@(negedge clk);
	chk(cha, 0);
	si = 12'h000;
	// Impulse: k-th output shows tap k alone
	for (int k = 1; k <= 9; k++) begin
		@(negedge clk);
		chk({fv, fo}, {1'h1, imp[k-1]});
	end
	sv = 0;
	@(negedge clk);
	chk(fv, 0);
	$display("filter done");
	complete_run();
end
endmodule
